/* File: include/frc_map.svh */
// Purpose: constants for the reset and configuration capture block
// Assumes: one 100 MHz clock
// Notes: encodings of the captured strap fields
`ifndef FRC_MAP_SVH
`define FRC_MAP_SVH
`define FRC_DATA_W 18
`define FRC_PTR_W 17
`define FRC_PTR_RESET 17'h00000
`define FRC_DATA_RESET 18'h00000
`define FRC_OFFSET_W 10
`define FRC_DEFAULT_0 10'h07F
`define FRC_DEFAULT_1 10'h3FF
`define FRC_DEFAULT_2 10'h00F
`define FRC_DEFAULT_3 10'h01F
`define FRC_DEFAULT_4 10'h03F
`define FRC_DEFAULT_5 10'h007
`define FRC_DEFAULT_6 10'h0FF
`define FRC_DEFAULT_7 10'h1FF
`endif

/* File: include/frc_pkg.sv */
// Purpose: types for the reset and configuration capture block
// Assumes: frc_map.svh included for widths
// Notes: configuration travels as one packed struct
package frc_pkg;
   typedef enum logic [1:0] {
      FRC_IN_RESET = 2'h1,
      FRC_RUNNING = 2'h2
   } frc_state_t;

   typedef struct packed {
      logic fall_through;
      logic write_x9;
      logic read_x9;
      logic big_endian;
      logic zero_latency;
      logic parity_interspersed;
      logic flag_sync;
      logic serial_program;
      logic [2:0] default_index;
   } frc_config_t;
endpackage

/* File: design/frc_config_latch.sv */
// Purpose: holds strap selections captured during master reset
// Assumes: straps synchronous to clk
// Notes: value frozen while master reset is inactive
`timescale 1ns/1ps
`default_nettype none
module frc_config_latch
   import frc_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic capture,
   input wire frc_config_t straps,
   output var frc_config_t config_q
);
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         config_q <= '0;
      end else if (capture) begin
         config_q <= straps;
      end
      // held otherwise, later strap changes ignored
   end
endmodule
`default_nettype wire

/* File: design/frc_reset_capture.sv */
// Purpose: master reset handling and strap capture for a FIFO
// Assumes: all pins synchronous to clk; master_reset active high
// Notes: pointers and output register cleared by master reset
`timescale 1ns/1ps
`default_nettype none
`include "frc_map.svh"
module frc_reset_capture
   import frc_pkg::*;
#(
   parameter int DATA_W = `FRC_DATA_W,
   parameter int PTR_W = `FRC_PTR_W
)(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic master_reset,
   input wire logic offset_load_n,
   input wire logic flag_default_select_0,
   input wire logic flag_default_select_1,
   input wire logic first_word_fall_through,
   input wire logic write_port_width,
   input wire logic read_port_width,
   input wire logic big_endian_select,
   input wire logic zero_latency_select,
   input wire logic parity_layout_select,
   input wire logic flag_timing_select,
   input wire logic output_enable_n,
   input wire logic write_advance,
   input wire logic read_advance,
   input wire logic [DATA_W-1:0] read_word,
   output logic [PTR_W-1:0] write_pointer,
   output logic [PTR_W-1:0] read_pointer,
   output logic [DATA_W-1:0] data_outputs,
   output logic data_outputs_oe,
   output logic [`FRC_OFFSET_W-1:0] default_offset,
   output logic serial_program,
   output logic offset_access_en,
   output logic fall_through_mode,
   output logic write_is_x9,
   output logic read_is_x9,
   output logic big_endian,
   output logic zero_latency,
   output logic parity_interspersed,
   output logic flag_sync,
   output logic configured
);
   // parameter values the capture logic cannot serve
   if (DATA_W != `FRC_DATA_W) begin : g_bad_data_w
      $error("frc_reset_capture: DATA_W must be 18");
   end
   if (PTR_W < 1 || PTR_W > `FRC_PTR_W) begin : g_bad_ptr_w
      $error("frc_reset_capture: PTR_W out of range");
   end

   function automatic logic [`FRC_OFFSET_W-1:0] default_of(
      input logic [2:0] idx);
      logic [`FRC_OFFSET_W-1:0] v;
      v = `FRC_DEFAULT_0;
      unique case (idx)
         3'h0: v = `FRC_DEFAULT_0;
         3'h1: v = `FRC_DEFAULT_1;
         3'h2: v = `FRC_DEFAULT_2;
         3'h3: v = `FRC_DEFAULT_3;
         3'h4: v = `FRC_DEFAULT_4;
         3'h5: v = `FRC_DEFAULT_5;
         3'h6: v = `FRC_DEFAULT_6;
         3'h7: v = `FRC_DEFAULT_7;
      endcase
      return v;
   endfunction

   // pointer step, wraps at the top of the memory
   function automatic logic [PTR_W-1:0] bump(input logic [PTR_W-1:0] p);
      return PTR_W'(p + 1'b1);
   endfunction

   frc_state_t state;
   frc_config_t straps;
   frc_config_t config_q;

   // strap pins gathered into the captured form
   always_comb begin
      straps.fall_through = first_word_fall_through;
      straps.write_x9 = write_port_width;
      straps.read_x9 = read_port_width;
      straps.big_endian = big_endian_select;
      straps.zero_latency = zero_latency_select;
      straps.parity_interspersed = parity_layout_select;
      straps.flag_sync = flag_timing_select;
      straps.serial_program = offset_load_n;
      straps.default_index = {offset_load_n, flag_default_select_1,
         flag_default_select_0};
   end

   // frozen copy, loaded only while master reset is high
   frc_config_latch u_latch (
      .clk(clk),
      .rst_n(rst_n),
      .capture(master_reset),
      .straps(straps),
      .config_q(config_q)
   );

   // running once master reset has been released
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state <= FRC_IN_RESET;
      end else begin
         unique case (state)
            FRC_IN_RESET: begin
               if (!master_reset) begin
                  state <= FRC_RUNNING;
               end
            end
            FRC_RUNNING: begin
               if (master_reset) begin
                  state <= FRC_IN_RESET;
               end
            end
            default: state <= FRC_IN_RESET;
         endcase
      end
   end

   // pointers restart at zero on master reset
   always_ff @(posedge clk) begin
      if (!rst_n || master_reset) begin
         write_pointer <= PTR_W'(`FRC_PTR_RESET);
      end else if (write_advance) begin
         write_pointer <= bump(write_pointer);
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n || master_reset) begin
         read_pointer <= PTR_W'(`FRC_PTR_RESET);
      end else if (read_advance) begin
         read_pointer <= bump(read_pointer);
      end
   end

   // output register, cleared by master reset
   always_ff @(posedge clk) begin
      if (!rst_n || master_reset) begin
         data_outputs <= DATA_W'(`FRC_DATA_RESET);
      end else if (read_advance) begin
         data_outputs <= read_word;
      end
   end

   // drive enable, high while the data outputs are driven
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         data_outputs_oe <= 1'b0;
      end else begin
         data_outputs_oe <= !output_enable_n;
      end
   end

   // after master reset the load pin gates offset access
   always_ff @(posedge clk) begin
      if (!rst_n || master_reset) begin
         offset_access_en <= 1'b0;
      end else begin
         offset_access_en <= !offset_load_n;
      end
   end

   // load strap picks the default table entry and the method
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         default_offset <= `FRC_DEFAULT_0;
         serial_program <= 1'b0;
      end else begin
         default_offset <= default_of(config_q.default_index);
         serial_program <= config_q.serial_program;
      end
   end

   // timing, width, byte order, parity and flag timing modes
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         fall_through_mode <= 1'b0;
         write_is_x9 <= 1'b0;
         read_is_x9 <= 1'b0;
         big_endian <= 1'b0;
         zero_latency <= 1'b0;
         parity_interspersed <= 1'b0;
         flag_sync <= 1'b0;
      end else begin
         fall_through_mode <= config_q.fall_through;
         write_is_x9 <= config_q.write_x9;
         read_is_x9 <= config_q.read_x9;
         big_endian <= config_q.big_endian;
         zero_latency <= config_q.zero_latency;
         parity_interspersed <= config_q.parity_interspersed;
         flag_sync <= config_q.flag_sync;
      end
   end

   // high once master reset has ended and the straps are frozen
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         configured <= 1'b0;
      end else begin
         configured <= (state == FRC_RUNNING);
      end
   end
endmodule
`default_nettype wire

/* File: tb/frc_strap_model.sv */
// Purpose: outside logic driving master reset and strap pins
// Assumes: all pins change just after a rising clock edge
// Notes: load pin doubles as strap and access request
`timescale 1ns/1ps
`default_nettype none
module frc_strap_model
   import frc_pkg::*;
(
   input wire logic clk,
   input wire logic mr_req,
   input wire logic load_req,
   input wire frc_config_t want,
   output var frc_config_t pins,
   output logic master_reset,
   output logic offset_load_n
);
   always_ff @(posedge clk) begin
      master_reset <= mr_req;
      pins <= want;
      offset_load_n <= mr_req ? want.serial_program : !load_req;
   end
endmodule
`default_nettype wire

/* File: tb/frc_reset_capture_properties.sv */
// Purpose: port checks for the reset and capture block
// Assumes: captured straps show two edges after sampling
// Notes: bound to every instance
`timescale 1ns/1ps
`default_nettype none
module frc_reset_capture_properties
   import frc_pkg::*;
#(parameter int DATA_W = 18, parameter int PTR_W = 17)(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic master_reset,
   input wire logic offset_load_n,
   input wire logic write_port_width,
   input wire logic read_port_width,
   input wire logic output_enable_n,
   input wire logic [PTR_W-1:0] write_pointer,
   input wire logic [PTR_W-1:0] read_pointer,
   input wire logic [DATA_W-1:0] data_outputs,
   input wire logic data_outputs_oe,
   input wire logic serial_program,
   input wire logic offset_access_en,
   input wire logic write_is_x9,
   input wire logic read_is_x9
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   a_ptr_clear: assert property (master_reset |=>
      write_pointer == '0 && read_pointer == '0) else $error("ptr not zero");
   a_data_clear: assert property (master_reset |=>
      data_outputs == '0) else $error("data not zero");
   a_oe_drive: assert property (!output_enable_n |=>
      data_outputs_oe) else $error("oe not driving");
   a_oe_float: assert property (output_enable_n |=>
      !data_outputs_oe) else $error("oe still driving");
   a_access_follow: assert property (!master_reset |=>
      offset_access_en == !$past(offset_load_n)) else $error("access wrong");
   a_read_width: assert property (master_reset |=> ##1
      read_is_x9 == $past(read_port_width, 2)) else $error("read width");
   a_write_width: assert property (master_reset |=> ##1
      write_is_x9 == $past(write_port_width, 2)) else $error("write width");
   a_serial_pick: assert property (master_reset |=> ##1
      serial_program == $past(offset_load_n, 2)) else $error("method");
   a_config_hold: assert property (!master_reset [*3] |=>
      $stable({write_is_x9, read_is_x9, serial_program})) else $error("drift");
   c_strap: cover property (master_reset ##1 !master_reset);
   c_access: cover property (offset_access_en);
   c_drive: cover property (data_outputs_oe);
endmodule
bind frc_reset_capture frc_reset_capture_properties
   #(.DATA_W(DATA_W), .PTR_W(PTR_W)) frc_reset_capture_properties_inst (
   .clk, .rst_n, .master_reset, .offset_load_n, .write_port_width,
   .read_port_width, .output_enable_n, .write_pointer, .read_pointer,
   .data_outputs, .data_outputs_oe, .serial_program, .offset_access_en,
   .write_is_x9, .read_is_x9);
`default_nettype wire

/* File: tb/frc_reset_capture_test.sv */
// Purpose: self-checking bench for the reset and capture block
// Assumes: strap model drives master reset and straps
// Notes: outputs read 1 ns after an edge
`timescale 1ns/1ps
`default_nettype none
`include "frc_map.svh"
module frc_reset_capture_test;
   import frc_pkg::*;
   logic clk = 0, rst_n = 0, mr_req = 0, load_req = 0, oen = 1, wa = 0, ra = 0;
   logic [17:0] rw = 18'h2AB5C;
   frc_config_t want = '0, pins;
   logic mr, ldn, oe, sp, acc, fw, wx, rx, be, zl, pi, fs, cfg;
   logic [16:0] wp, rp;
   logic [17:0] dq;
   logic [9:0] dofs;
   logic [9:0] tbl [8] = '{`FRC_DEFAULT_0, `FRC_DEFAULT_1, `FRC_DEFAULT_2,
      `FRC_DEFAULT_3, `FRC_DEFAULT_4, `FRC_DEFAULT_5, `FRC_DEFAULT_6,
      `FRC_DEFAULT_7};
   int mismatches = 0, checks_done = 0;
   always #5 clk = ~clk;
   frc_strap_model frc_strap_model_inst (.clk, .mr_req, .load_req, .want,
      .pins, .master_reset(mr), .offset_load_n(ldn));
   frc_reset_capture frc_reset_capture_inst (.clk, .rst_n,
      .master_reset(mr), .offset_load_n(ldn),
      .flag_default_select_0(pins.default_index[0]),
      .flag_default_select_1(pins.default_index[1]),
      .first_word_fall_through(pins.fall_through),
      .write_port_width(pins.write_x9),
      .read_port_width(pins.read_x9), .big_endian_select(pins.big_endian),
      .zero_latency_select(pins.zero_latency),
      .parity_layout_select(pins.parity_interspersed),
      .flag_timing_select(pins.flag_sync), .output_enable_n(oen),
      .write_advance(wa), .read_advance(ra), .read_word(rw),
      .write_pointer(wp), .read_pointer(rp), .data_outputs(dq),
      .data_outputs_oe(oe), .default_offset(dofs), .serial_program(sp),
      .offset_access_en(acc), .fall_through_mode(fw), .write_is_x9(wx),
      .read_is_x9(rx), .big_endian(be), .zero_latency(zl),
      .parity_interspersed(pi), .flag_sync(fs), .configured(cfg));
   task check(input logic [63:0] seen, input logic [63:0] exp);
      checks_done++;
      if (seen !== exp) begin
         mismatches++;
         $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task give_verdict;
      if (mismatches == 0 && checks_done > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task at(input int n);
      repeat (n) @(posedge clk);
   endtask
   task strap_and_hold(input int i);
      frc_config_t c;
      c = frc_config_t'({7'(i * 19), i[2], i[2:0]});
      at(1);
      want <= c;
      mr_req <= 1;
      at(4);
      mr_req <= 0;
      at(4);
      #1;
      check(fw, c.fall_through);
      check({be, zl}, {c.big_endian, c.zero_latency});
      check(rx, c.read_x9);
      check(wx, c.write_x9);
      check(fs, c.flag_sync);
      check(pi, c.parity_interspersed);
      check(sp, c.serial_program);
      check(dofs, tbl[i]);
      check(cfg, 1'h1);
      at(1);
      want <= ~c;
      at(4);
      #1;
      check({fw, wx, rx, be, zl, pi, fs, sp}, c[10:3]);
      check(dofs, tbl[i]);
   endtask
   task access_and_drive;
      at(1);
      load_req <= 1;
      oen <= 0;
      at(3);
      #1;
      check({acc, oe}, 2'h3);
      at(1);
      load_req <= 0;
      oen <= 1;
      at(3);
      #1;
      check({acc, oe}, 2'h0);
   endtask
   task clear_on_reset;
      at(1);
      wa <= 1;
      ra <= 1;
      at(3);
      wa <= 0;
      ra <= 0;
      at(1);
      #1;
      check({wp, rp, dq}, {17'h00003, 17'h00003, 18'h2AB5C});
      at(1);
      mr_req <= 1;
      at(3);
      #1;
      check({wp, rp, dq}, 52'h0);
      at(1);
      mr_req <= 0;
   endtask
   initial begin
      at(10);
      rst_n <= 1;
      for (int i = 0; i < 8; i++) strap_and_hold(i);
      access_and_drive();
      clear_on_reset();
      give_verdict();
   end
   initial begin
      #20000;
      mismatches++;
      give_verdict();
   end
endmodule
`default_nettype wire
